// ===== logic/tpg_pkg.sv
// Purpose: constants shared by the timer/pwm block
// Assumes: byte-wide register port, two channels
// Notes:   offsets are register byte addresses on the local port

package tpg_pkg;

	localparam int          NCH        = 2;
	localparam int          CW         = 16;

	// register offsets
	localparam logic [7:0]  A_CTRL     = 8'h00;
	localparam logic [7:0]  A_CNTH     = 8'h01;
	localparam logic [7:0]  A_CNTL     = 8'h02;
	localparam logic [7:0]  A_MODH     = 8'h03;
	localparam logic [7:0]  A_MODL     = 8'h04;
	localparam logic [7:0]  A_STAT     = 8'h05;
	localparam logic [7:0]  A_MASK     = 8'h06;
	// channel n occupies 8*A_CHBASE + 4*n .. +2 (A_CHBASE is matched against address bits 7:3)
	localparam logic [4:0]  A_CHBASE   = 5'h01;
	localparam logic [1:0]  CH_SC      = 2'h0;
	localparam logic [1:0]  CH_VH      = 2'h1;
	localparam logic [1:0]  CH_VL      = 2'h2;

	// control register fields
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_CENTER_ALIGNED_SELECT = 5;

	// status/mask: bit n is channel n, bit NCH is overflow
	localparam int          ST_OVF     = NCH;

	// channel status/control fields
	localparam int          SC_ELSA    = 2;
	localparam int          SC_ELSB    = 3;
	localparam int          SC_MODE    = 4;
	localparam int          SC_FLAG    = 7;

	// channel modes
	localparam logic [1:0]  MODE_OFF   = 2'h0;
	localparam logic [1:0]  MODE_OC    = 2'h1;
	localparam logic [1:0]  MODE_EPWM  = 2'h2;

	// counter values
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_ONE    = 16'h0001;
	localparam logic [15:0] CNT_FULL   = 16'hffff;
	localparam logic [15:0] VAL_RST    = 16'h0000;

endpackage

// ===== logic/tpg_timer_pwm.sv
// Purpose: 16-bit timer with output compare and edge-aligned pwm
// Assumes: one clock, synchronous reset, byte-wide register port
// Notes:   reads return data one cycle after the read strobe
//
// Operation
// - 16-bit counter: free, modulo, or up/down
// - modulus zero or all-ones means free running
// - counter reads never disturb counting
// - any counter byte write resets counter
// - compare match sets, clears or toggles pin
// - compare value moves after both bytes written
// - status/control write restarts byte pairing
// - compare match sets flag, may interrupt
// - edge pwm needs up-counting, centre select clear
// - modulus sets period, channel value duty
// - pulse spans overflow to compare match
// - select A inverts overflow and match levels
// - channel value zero gives zero duty
// - value above modulus gives full duty
// - channel byte writes land in buffer
// - pwm value moves at counter zero

`timescale 1ns/1ps
`default_nettype none

module tpg_timer_pwm (
	input  wire logic                    I_CORE_CLK,
	input  wire logic                    I_SRST,
	input  wire logic [7:0]              I_ADDR,
	input  wire logic [7:0]              I_WDATA,
	input  wire logic                    I_WR,
	input  wire logic                    I_RD,
	output var  logic [7:0]              O_RDATA,
	output var  logic [tpg_pkg::NCH-1:0] O_CH_PIN,
	output var  logic                    O_IRQ
);

	////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0]                   cnt;
		logic                          dir_down;
		logic                          en;
		logic                          center_aligned_select;
		logic [15:0]                   modulus;
		logic [tpg_pkg::NCH:0]         status;
		logic [tpg_pkg::NCH:0]         mask;
		logic [tpg_pkg::NCH-1:0][1:0]  mode;
		logic [tpg_pkg::NCH-1:0]       elsa;
		logic [tpg_pkg::NCH-1:0]       elsb;
		logic [tpg_pkg::NCH-1:0][15:0] val;
		logic [tpg_pkg::NCH-1:0][15:0] buff;
		logic [tpg_pkg::NCH-1:0]       hi_wr;
		logic [tpg_pkg::NCH-1:0]       lo_wr;
		logic [tpg_pkg::NCH-1:0]       pin;
		logic [7:0]                    rdata;
		logic                          irq;
	} tpg_state_t;

	tpg_state_t r;
	tpg_state_t next_r;

	////////////////////////////////////////////////////////////////////
	// address decode

	logic                  ch_hit;
	logic [0:0]            ch_sel;
	logic [1:0]            ch_reg;
	logic                  cnt_wr;
	logic                  free_run;
	logic [15:0]           top;
	logic                  wr_ctrl;
	logic                  wr_mod_hi;
	logic                  wr_mod_lo;
	logic                  wr_stat;
	logic                  wr_mask;

	// one strobe per common register keeps the next-state process flat
	assign wr_ctrl   = I_WR && (I_ADDR == tpg_pkg::A_CTRL);
	assign wr_mod_hi = I_WR && (I_ADDR == tpg_pkg::A_MODH);
	assign wr_mod_lo = I_WR && (I_ADDR == tpg_pkg::A_MODL);
	assign wr_stat   = I_WR && (I_ADDR == tpg_pkg::A_STAT);
	assign wr_mask   = I_WR && (I_ADDR == tpg_pkg::A_MASK);

	assign ch_hit = (I_ADDR[7:3] == tpg_pkg::A_CHBASE);
	assign ch_sel = I_ADDR[2];
	assign ch_reg = I_ADDR[1:0];
	assign cnt_wr = I_WR && (I_ADDR == tpg_pkg::A_CNTH ||
		I_ADDR == tpg_pkg::A_CNTL);

	// both extreme settings give the full 16-bit range
	assign free_run = (r.modulus == tpg_pkg::CNT_ZERO) ||
		(r.modulus == tpg_pkg::CNT_FULL);
	assign top = free_run ? tpg_pkg::CNT_FULL : r.modulus;

	////////////////////////////////////////////////////////////////////
	// per-channel value transfer and compare

	logic [tpg_pkg::NCH-1:0]       xfer;
	logic [tpg_pkg::NCH-1:0][15:0] eff_val;
	logic [tpg_pkg::NCH-1:0]       oc_match;
	logic [tpg_pkg::NCH-1:0]       pwm_match;
	logic [tpg_pkg::NCH-1:0]       pwm_start;
	logic [tpg_pkg::NCH-1:0]       ch_wr;
	logic                          cnt_is_zero;
	// per-channel next values, gathered by the main process
	logic [tpg_pkg::NCH-1:0]       ev_ch;
	logic [tpg_pkg::NCH-1:0]       pin_nx;
	logic [tpg_pkg::NCH-1:0][1:0]  mode_nx;
	logic [tpg_pkg::NCH-1:0]       elsa_nx;
	logic [tpg_pkg::NCH-1:0]       elsb_nx;
	logic [tpg_pkg::NCH-1:0][15:0] val_nx;
	logic [tpg_pkg::NCH-1:0][15:0] buff_nx;
	logic [tpg_pkg::NCH-1:0]       hi_nx;
	logic [tpg_pkg::NCH-1:0]       lo_nx;
	// per-channel read view
	logic [tpg_pkg::NCH-1:0][7:0]  ch_rd;

	assign cnt_is_zero = (r.cnt == tpg_pkg::CNT_ZERO);

	genvar g;
	generate
		for (g = 0; g < tpg_pkg::NCH; g++) begin : g_ch
			// pwm waits for the period start so a half-updated
			// duty never reaches the pin
			assign xfer[g] = r.hi_wr[g] && r.lo_wr[g] &&
				(r.mode[g] != tpg_pkg::MODE_EPWM ||
				cnt_is_zero);
			assign eff_val[g] = xfer[g] ? r.buff[g] : r.val[g];
			assign oc_match[g] = r.en &&
				(r.mode[g] == tpg_pkg::MODE_OC) &&
				(r.cnt == r.val[g]);
			// with centre select set the pwm channel just holds
			assign pwm_match[g] = r.en && !r.center_aligned_select &&
				(r.mode[g] == tpg_pkg::MODE_EPWM) &&
				(r.cnt == eff_val[g]);
			assign pwm_start[g] = r.en && !r.center_aligned_select && cnt_is_zero &&
				(r.mode[g] == tpg_pkg::MODE_EPWM);
			assign ch_wr[g] = I_WR && ch_hit && (ch_sel == 1'(g));

			always_comb begin
				pin_nx[g]  = r.pin[g];
				ev_ch[g]   = 1'b0;
				mode_nx[g] = r.mode[g];
				elsa_nx[g] = r.elsa[g];
				elsb_nx[g] = r.elsb[g];
				val_nx[g]  = r.val[g];
				buff_nx[g] = r.buff[g];
				hi_nx[g]   = r.hi_wr[g];
				lo_nx[g]   = r.lo_wr[g];
				if (oc_match[g]) begin
					ev_ch[g] = 1'b1;
					case ({r.elsb[g], r.elsa[g]})
						2'h1: pin_nx[g] = !r.pin[g];
						2'h2: pin_nx[g] = 1'b0;
						2'h3: pin_nx[g] = 1'b1;
						default: pin_nx[g] = r.pin[g];
					endcase
				end
				// match checked first: zero value means zero duty,
				// a value past the modulus never matches
				if (pwm_match[g]) begin
					ev_ch[g] = 1'b1;
					pin_nx[g] = r.elsa[g];
				end else if (pwm_start[g]) begin
					pin_nx[g] = !r.elsa[g];
				end
				if (xfer[g]) begin
					val_nx[g] = r.buff[g];
					hi_nx[g] = 1'b0;
					lo_nx[g] = 1'b0;
				end
				if (ch_wr[g]) begin
					case (ch_reg)
						tpg_pkg::CH_SC: begin
							mode_nx[g] = I_WDATA[tpg_pkg::SC_MODE +: 2];
							elsa_nx[g] = I_WDATA[tpg_pkg::SC_ELSA];
							elsb_nx[g] = I_WDATA[tpg_pkg::SC_ELSB];
							hi_nx[g] = 1'b0;
							lo_nx[g] = 1'b0;
						end
						tpg_pkg::CH_VH: begin
							buff_nx[g][15:8] = I_WDATA;
							hi_nx[g] = 1'b1;
						end
						tpg_pkg::CH_VL: begin
							buff_nx[g][7:0] = I_WDATA;
							lo_nx[g] = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end

			// read view: active value, never the buffer
			always_comb begin
				ch_rd[g] = 8'h00;
				case (ch_reg)
					tpg_pkg::CH_SC: begin
						ch_rd[g][tpg_pkg::SC_MODE +: 2] = r.mode[g];
						ch_rd[g][tpg_pkg::SC_ELSA] = r.elsa[g];
						ch_rd[g][tpg_pkg::SC_ELSB] = r.elsb[g];
						ch_rd[g][tpg_pkg::SC_FLAG] = r.status[g];
					end
					tpg_pkg::CH_VH: ch_rd[g] = r.val[g][15:8];
					tpg_pkg::CH_VL: ch_rd[g] = r.val[g][7:0];
					default: ch_rd[g] = 8'h00;
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// counter

	logic [15:0]           cnt_nx;
	logic                  dir_nx;
	logic                  ovf;

	always_comb begin
		cnt_nx = r.cnt;
		dir_nx = r.dir_down;
		ovf = 1'b0;
		if (r.en) begin
			if (!r.center_aligned_select) begin
				dir_nx = 1'b0;
				if (r.cnt == top) begin
					cnt_nx = tpg_pkg::CNT_ZERO;
					ovf = 1'b1;
				end else begin
					cnt_nx = r.cnt + tpg_pkg::CNT_ONE;
				end
			end else if (r.dir_down) begin
				if (cnt_is_zero) begin
					dir_nx = 1'b0;
					cnt_nx = tpg_pkg::CNT_ONE;
					ovf = 1'b1;
				end else begin
					cnt_nx = r.cnt - tpg_pkg::CNT_ONE;
				end
			end else if (r.cnt >= top) begin
				dir_nx = 1'b1;
				cnt_nx = r.cnt - tpg_pkg::CNT_ONE;
			end else begin
				cnt_nx = r.cnt + tpg_pkg::CNT_ONE;
			end
		end
		// data written to the counter is thrown away
		if (cnt_wr) begin
			cnt_nx = tpg_pkg::CNT_ZERO;
			dir_nx = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [tpg_pkg::NCH:0] ev;
		logic [tpg_pkg::NCH:0] clr;
		next_r = r;
		ev = '0;
		clr = '0;
		next_r.rdata = 8'h00;
		next_r.cnt = cnt_nx;
		next_r.dir_down = dir_nx;

		// channels
		next_r.pin   = pin_nx;
		next_r.mode  = mode_nx;
		next_r.elsa  = elsa_nx;
		next_r.elsb  = elsb_nx;
		next_r.val   = val_nx;
		next_r.buff  = buff_nx;
		next_r.hi_wr = hi_nx;
		next_r.lo_wr = lo_nx;
		ev[tpg_pkg::NCH-1:0] = ev_ch;
		ev[tpg_pkg::ST_OVF] = ovf;

		// control and common registers
		if (wr_ctrl) begin
			next_r.en = I_WDATA[tpg_pkg::CTRL_EN];
			next_r.center_aligned_select = I_WDATA[tpg_pkg::CTRL_CENTER_ALIGNED_SELECT];
		end
		// modulus bytes act one at a time, no pairing
		if (wr_mod_hi) begin
			next_r.modulus[15:8] = I_WDATA;
		end
		if (wr_mod_lo) begin
			next_r.modulus[7:0] = I_WDATA;
		end
		if (wr_stat) begin
			clr = I_WDATA[tpg_pkg::NCH:0];
		end
		if (wr_mask) begin
			next_r.mask = I_WDATA[tpg_pkg::NCH:0];
		end
		// an event in the clearing cycle survives the clear
		next_r.status = (r.status & ~clr) | ev;
		next_r.irq = |(next_r.status & next_r.mask);

		// read data, present only in the cycle after the strobe
		if (I_RD) begin
			if (ch_hit) begin
				next_r.rdata = ch_rd[ch_sel];
			end else begin
				case (I_ADDR)
					tpg_pkg::A_CTRL: begin
						next_r.rdata[tpg_pkg::CTRL_EN] = r.en;
						next_r.rdata[tpg_pkg::CTRL_CENTER_ALIGNED_SELECT] = r.center_aligned_select;
					end
					// live value, no side effect on counting
					tpg_pkg::A_CNTH: next_r.rdata = r.cnt[15:8];
					tpg_pkg::A_CNTL: next_r.rdata = r.cnt[7:0];
					tpg_pkg::A_MODH: next_r.rdata = r.modulus[15:8];
					tpg_pkg::A_MODL: next_r.rdata = r.modulus[7:0];
					tpg_pkg::A_STAT:
						next_r.rdata[tpg_pkg::NCH:0] = r.status;
					tpg_pkg::A_MASK:
						next_r.rdata[tpg_pkg::NCH:0] = r.mask;
					default: next_r.rdata = 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge I_CORE_CLK) begin
		if (I_SRST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign O_RDATA  = r.rdata;
	assign O_CH_PIN = r.pin;
	assign O_IRQ    = r.irq;

endmodule

`default_nettype wire

// ===== verification/tpg_timer_pwm_asserts.sv
// Purpose: port-level checks of the timer/pwm block
// Assumes: bound to the top module, one clock domain
// Notes:   readbacks expect one idle cycle after the write
`timescale 1ns/1ps
`default_nettype none

module tpg_timer_pwm_asserts (
	input wire logic                    I_CORE_CLK,
	input wire logic                    I_SRST,
	input wire logic [7:0]              I_ADDR,
	input wire logic [7:0]              I_WDATA,
	input wire logic                    I_WR,
	input wire logic                    I_RD,
	input wire logic [7:0]              O_RDATA,
	input wire logic [tpg_pkg::NCH-1:0] O_CH_PIN,
	input wire logic                    O_IRQ
);
////////////////////////////////
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SRST);

	a_reset_quiet: assert property (
		$fell(I_SRST) |-> (O_CH_PIN == '0) && !O_IRQ)
		else $error("outputs busy after reset");
	a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property (
		I_RD && I_ADDR == 8'h07 |=> O_RDATA == 8'h00)
		else $error("unmapped read not zero");
	// data written to the counter must not survive
	a_cnt_clear: assert property (
		I_WR && I_ADDR inside {8'h01, 8'h02} ##2 I_RD && I_ADDR == 8'h02
		|=> O_RDATA <= 8'h01)
		else $error("counter not cleared");
	a_mod_back: assert property (
		I_WR && I_ADDR == 8'h04 ##2 I_RD && I_ADDR == 8'h04
		|=> O_RDATA == $past(I_WDATA, 3))
		else $error("modulus readback");
	a_ctrl_back: assert property (
		I_WR && I_ADDR == 8'h00 ##2 I_RD && I_ADDR == 8'h00
		|=> (O_RDATA & 8'h21) == ($past(I_WDATA, 3) & 8'h21))
		else $error("control readback");
	// flag bit may move, so only mode and edge bits
	a_sc_back: assert property (
		I_WR && I_ADDR == 8'h08 ##2 I_RD && I_ADDR == 8'h08
		|=> (O_RDATA & 8'h3c) == ($past(I_WDATA, 3) & 8'h3c))
		else $error("channel control readback");
	a_irq_masked: assert property (
		I_WR && I_ADDR == 8'h06 && I_WDATA[2:0] == 3'h0 |=> ##1 !O_IRQ)
		else $error("masked interrupt high");
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Purpose: directed tests of the timer/pwm block
// Assumes: modulus 5 gives a 6-cycle period
// Notes:   bus tasks leave one idle cycle between accesses
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                    clk = 1'b0;
	logic                    srst = 1'b1;
	logic [7:0]              addr = 8'h00;
	logic [7:0]              wdata = 8'h00;
	logic                    wr = 1'b0;
	logic                    rd = 1'b0;
	logic [7:0]              rdata;
	logic [tpg_pkg::NCH-1:0] pin;
	logic                    irq;
	int                      bad_count = 0;
	int                      n_tests = 0;
	logic                    p;
	logic [7:0]              n;

	always #10 clk = ~clk;

	tpg_timer_pwm dut_u (
		.I_CORE_CLK(clk),
		.I_SRST    (srst),
		.I_ADDR    (addr),
		.I_WDATA   (wdata),
		.I_WR      (wr),
		.I_RD      (rd),
		.O_RDATA   (rdata),
		.O_CH_PIN  (pin),
		.O_IRQ     (irq)
	);
////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, e);
	endtask

	task automatic conclude;
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
////////////////////////////////
	// counter stopped here, so no compare match can set the flag
	task automatic t_reset;
		rreg(8'h05, 8'h00);
		rreg(8'h07, 8'h00);
		wreg(8'h00, 8'h20);
		rreg(8'h00, 8'h20);
		wreg(8'h08, 8'h1c);
		rreg(8'h08, 8'h1c);
		wreg(8'h08, 8'h00);
	endtask

	task automatic t_count;
		wreg(8'h04, 8'h05);
		rreg(8'h04, 8'h05);
		wreg(8'h00, 8'h01);
		wreg(8'h02, 8'h5a);
		for (int i = 0; i < 6; i++)
			rreg(8'h02, 8'((2 * i + 1) % 6));
		wreg(8'h04, 8'h00);
		wreg(8'h01, 8'h77);
		for (int i = 0; i < 6; i++)
			rreg(8'h02, 8'(2 * i + 1));
		wreg(8'h04, 8'h05);
		// counter is far past 5 here and would run to 0xffff first
		wreg(8'h01, 8'h00);
	endtask

	task automatic t_oc;
		wreg(8'h09, 8'h00);
		wreg(8'h08, 8'h1c);
		wreg(8'h0a, 8'h03);
		rreg(8'h0a, 8'h00);
		wreg(8'h09, 8'h00);
		rreg(8'h0a, 8'h03);
		repeat (8) @(posedge clk);
		#1 check(8'(pin[0]), 8'h01);
		rreg(8'h08, 8'h9c);
		rreg(8'h05, 8'h05);
		wreg(8'h08, 8'h18);
		repeat (8) @(posedge clk);
		#1 check(8'(pin[0]), 8'h00);
		wreg(8'h08, 8'h14);
		@(posedge clk);
		#1 p = pin[0];
		repeat (6) @(posedge clk);
		#1 check(8'(pin[0]), 8'(!p));
	endtask

	task automatic irqchk(input logic [7:0] e);
		@(posedge clk);
		#1 check(8'(irq), e);
	endtask

	task automatic t_irq;
		wreg(8'h06, 8'h02);
		irqchk(8'h00);
		wreg(8'h06, 8'h01);
		irqchk(8'h01);
		wreg(8'h00, 8'h00);
		wreg(8'h08, 8'h00);
		wreg(8'h05, 8'h05);
		irqchk(8'h00);
		rreg(8'h05, 8'h00);
		wreg(8'h06, 8'h00);
		wreg(8'h00, 8'h01);
	endtask

	// ch1 pwm while ch0 sits idle; value moves only at count zero
	task automatic t_pwm;
		logic [7:0] sc [4] = '{8'h20, 8'h20, 8'h20, 8'h24};
		logic [7:0] v [4]  = '{8'h02, 8'h00, 8'h06, 8'h02};
		logic [7:0] e [4]  = '{8'h02, 8'h00, 8'h06, 8'h04};
		for (int i = 0; i < 4; i++) begin
			wreg(8'h0c, sc[i]);
			wreg(8'h0d, 8'h00);
			wreg(8'h0e, v[i]);
			repeat (12) @(posedge clk);
			n = 8'h00;
			repeat (6) begin
				@(posedge clk);
				#1 n = n + 8'(pin[1]);
			end
			check(n, e[i]);
		end
	endtask
////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		t_count;
		t_oc;
		t_irq;
		t_pwm;
		conclude;
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		conclude;
	end
endmodule

bind tpg_timer_pwm tpg_timer_pwm_asserts chk_u (.I_CORE_CLK, .I_SRST,
	.I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .O_CH_PIN, .O_IRQ);
`default_nettype wire
